/* src/cmp_ctrl_pkg.sv */
// ==========================================================================
// Shared constants and carriers for the comparator control block.
package cmp_ctrl_pkg;

  // ========================================================================
  // Special-function register addresses.
  localparam logic [7:0] ctrl_addr       = 8'h9b;
  localparam logic [7:0] mode_addr       = 8'h9d;

  // ========================================================================
  // Control register field positions and reset value.
  localparam int         ctl_on_bit      = 7;
  localparam int         ctl_result_bit  = 6;
  localparam int         ctl_rise_bit    = 5;
  localparam int         ctl_fall_bit    = 4;
  localparam int         ctl_hyp_lsb     = 2;
  localparam int         ctl_hyn_lsb     = 0;
  localparam logic [7:0] ctrl_reset      = 8'h00;

  // ========================================================================
  // Mode register field positions and reset value.
  localparam int         mode_rie_bit    = 5;
  localparam int         mode_fie_bit    = 4;
  localparam int         mode_speed_lsb  = 0;
  localparam logic [1:0] speed_reset     = 2'h2;
  localparam logic [7:0] mode_reset      = 8'h02;

  // ========================================================================
  // Settings sent to the analog core.
  typedef struct packed {
    logic       power_on;
    logic [1:0] positive_hysteresis_sel;
    logic [1:0] negative_hysteresis_sel;
    logic [1:0] response_speed_sel;
  } analog_cfg_t;

endpackage

/* src/comparator_digital_control.sv */
`timescale 1ns/1ns
// Functional notes
// - Comparator powered and running only while the enable bit is one.
// - Disabled comparator forces routed outputs low and removes its supply.
// - Result bit reads one when positive input exceeds negative, readable anytime.
// - Each rising output edge sets the sticky rising-edge flag.
// - Each falling output edge sets the sticky falling-edge flag.
// - Edge flags are read-write; only a software write of zero clears them.
// - Rising edge requests an interrupt only when its enable is set.
// - Falling edge requests an interrupt only when its enable is set.
// - Bits 3:2 select positive hysteresis for the analog core.
// - Bits 1:0 select negative hysteresis for the analog core.
// - Offer a latched clock-synchronised output and a raw asynchronous output.
// - Raw output follows the comparator without any clock, even in stop.
// - Comparator output also feeds chip reset and counter-array channel kill.
// - Control register at 0x9B, on every page, resets to zero.
// - Response-time setting passes to the analog core.
// - Mode register at 0x9D holds rise enable bit 5, fall enable bit 4.
// - Mode register response field selects modes zero to three, resets to two.
module comparator_digital_control
  import cmp_ctrl_pkg::*;
(
  // Clock and reset.
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // Special-function register bus.
  input  wire logic [7:0]  sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  input  wire logic [7:0]  sfr_wdata,
  output logic      [7:0]  sfr_rdata,
  // Analog comparator core.
  input  wire logic        core_compare,
  output analog_cfg_t      analog_cfg,
  // Comparator outputs to pins and system.
  output logic             latched_compare_out,
  output logic             raw_compare_out,
  output logic             reset_source,
  output logic             counter_array_kill,
  output logic             irq_request
);

  // ========================================================================
  // Register state.
  logic       comparator_on, next_comparator_on;
  logic       rise_edge_flag, next_rise_edge_flag;
  logic       fall_edge_flag, next_fall_edge_flag;
  logic [1:0] positive_hysteresis_sel, next_positive_hysteresis_sel;
  logic [1:0] negative_hysteresis_sel, next_negative_hysteresis_sel;
  logic       rise_irq_enable, next_rise_irq_enable;
  logic       fall_irq_enable, next_fall_irq_enable;
  logic [1:0] response_speed_sel, next_response_speed_sel;
  logic [7:0] next_sfr_rdata;
  logic       next_irq_request;

  // Synchroniser stages and previous-cycle value.
  logic       sync_a, sync_b, sync_c, compare_result, prev_result;
  logic       next_compare_result;
  logic       rise_seen, fall_seen;
  logic       ctrl_wr, mode_wr;

  // ========================================================================
  // Raw path: no flip-flop, so it keeps working when the clock stops.
  // raw clockless path
  always_comb begin
    // Combinational on purpose: this output must keep working while the clock is stopped.
    raw_compare_out = comparator_on & core_compare;
  end

  // Synchronise the core output through three stages; accept on agreement.
  // Only the second stage reads the first, so a metastable first stage stays contained.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_a         <= 1'b0;
      sync_b         <= 1'b0;
      sync_c         <= 1'b0;
      compare_result <= 1'b0;
      prev_result    <= 1'b0;
    end else begin
      sync_a         <= raw_compare_out;
      sync_b         <= sync_a;
      sync_c         <= sync_b;
      compare_result <= next_compare_result;
      prev_result    <= compare_result;
    end
  end

  // Update the accepted result only when stages two and three agree.
  always_comb begin
    next_compare_result = (sync_b == sync_c) ? sync_c : compare_result;
  end

  always_comb begin
    rise_seen = compare_result & ~prev_result;
    fall_seen = ~compare_result & prev_result;
  end

  // ========================================================================
  // Register writes and flag updates.
  // control decode
  always_comb begin
    ctrl_wr = sfr_wr && (sfr_addr == ctrl_addr);
    mode_wr = sfr_wr && (sfr_addr == mode_addr);
  end

  // Next register values; an edge wins over a clearing write in the same cycle.
  always_comb begin
    next_comparator_on           = comparator_on;
    next_positive_hysteresis_sel = positive_hysteresis_sel;
    next_negative_hysteresis_sel = negative_hysteresis_sel;
    next_rise_irq_enable         = rise_irq_enable;
    next_fall_irq_enable         = fall_irq_enable;
    next_response_speed_sel      = response_speed_sel;
    next_rise_edge_flag          = rise_edge_flag;
    next_fall_edge_flag          = fall_edge_flag;
    if (ctrl_wr) begin
      next_comparator_on           = sfr_wdata[ctl_on_bit];
      next_positive_hysteresis_sel = sfr_wdata[ctl_hyp_lsb +: 2];
      next_negative_hysteresis_sel = sfr_wdata[ctl_hyn_lsb +: 2];
      next_rise_edge_flag          = sfr_wdata[ctl_rise_bit];
      next_fall_edge_flag          = sfr_wdata[ctl_fall_bit];
    end
    if (mode_wr) begin
      next_rise_irq_enable    = sfr_wdata[mode_rie_bit];
      next_fall_irq_enable    = sfr_wdata[mode_fie_bit];
      next_response_speed_sel = sfr_wdata[mode_speed_lsb +: 2];
    end
    if (rise_seen) begin
      next_rise_edge_flag = 1'b1;
    end
    if (fall_seen) begin
      next_fall_edge_flag = 1'b1;
    end
  end

  // Read data, registered so the bus output comes from a flip-flop.
  always_comb begin
    next_sfr_rdata = 8'h00;
    if (sfr_rd && sfr_addr == ctrl_addr) begin
      next_sfr_rdata[ctl_on_bit]        = next_comparator_on;
      next_sfr_rdata[ctl_result_bit]    = compare_result;
      next_sfr_rdata[ctl_rise_bit]      = rise_edge_flag;
      next_sfr_rdata[ctl_fall_bit]      = fall_edge_flag;
      next_sfr_rdata[ctl_hyp_lsb +: 2]  = positive_hysteresis_sel;
      next_sfr_rdata[ctl_hyn_lsb +: 2]  = negative_hysteresis_sel;
    end else if (sfr_rd && sfr_addr == mode_addr) begin
      next_sfr_rdata[mode_rie_bit]        = rise_irq_enable;
      next_sfr_rdata[mode_fie_bit]        = fall_irq_enable;
      next_sfr_rdata[mode_speed_lsb +: 2] = response_speed_sel;
    end
  end

  always_comb begin
    next_irq_request = (next_rise_edge_flag & next_rise_irq_enable) |
                       (next_fall_edge_flag & next_fall_irq_enable);
  end

  // Register all state and every output except raw_compare_out.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      comparator_on           <= ctrl_reset[ctl_on_bit];
      rise_edge_flag          <= ctrl_reset[ctl_rise_bit];
      fall_edge_flag          <= ctrl_reset[ctl_fall_bit];
      positive_hysteresis_sel <= ctrl_reset[ctl_hyp_lsb +: 2];
      negative_hysteresis_sel <= ctrl_reset[ctl_hyn_lsb +: 2];
      rise_irq_enable         <= mode_reset[mode_rie_bit];
      fall_irq_enable         <= mode_reset[mode_fie_bit];
      response_speed_sel      <= speed_reset;
      sfr_rdata               <= 8'h00;
      irq_request             <= 1'b0;
      // The analog core sees the reset settings, response mode two included, during reset.
      analog_cfg              <= '{power_on:                ctrl_reset[ctl_on_bit],
                                   positive_hysteresis_sel: ctrl_reset[ctl_hyp_lsb +: 2],
                                   negative_hysteresis_sel: ctrl_reset[ctl_hyn_lsb +: 2],
                                   response_speed_sel:      speed_reset};
      latched_compare_out     <= 1'b0;
      reset_source            <= 1'b0;
      counter_array_kill      <= 1'b0;
    end else begin
      comparator_on           <= next_comparator_on;
      rise_edge_flag          <= next_rise_edge_flag;
      fall_edge_flag          <= next_fall_edge_flag;
      positive_hysteresis_sel <= next_positive_hysteresis_sel;
      negative_hysteresis_sel <= next_negative_hysteresis_sel;
      rise_irq_enable         <= next_rise_irq_enable;
      fall_irq_enable         <= next_fall_irq_enable;
      response_speed_sel      <= next_response_speed_sel;
      sfr_rdata               <= next_sfr_rdata;
      irq_request             <= next_irq_request;
      analog_cfg <= '{power_on:                next_comparator_on,
                      positive_hysteresis_sel: next_positive_hysteresis_sel,
                      negative_hysteresis_sel: next_negative_hysteresis_sel,
                      response_speed_sel:      next_response_speed_sel};
      latched_compare_out     <= next_compare_result & next_comparator_on;
      reset_source            <= next_compare_result & next_comparator_on;
      counter_array_kill      <= next_compare_result & next_comparator_on;
    end
  end

endmodule // comparator_digital_control

/* test/analog_core_model.sv */
`timescale 1ns/1ns
// ==========================================================
// Analog core stand-in: its result follows the commanded level.
module analog_core_model (
  // Commanded level and response speed.
  input  wire logic target,
  input  wire logic slow,
  // Compare result.
  output logic      core_out
);
  // The result starts low, then settles quickly or slowly after each change of the level.
  initial begin
    core_out = 1'b0;
    forever begin
      @(target);
      core_out <= #(slow ? 130 : 5) target;
    end
  end
endmodule // analog_core_model

/* test/comparator_digital_control_sva.sv */
`timescale 1ns/1ns
// ==========================================================
// Port-level checks of the comparator control block.
module comparator_digital_control_sva
  import cmp_ctrl_pkg::*;
(
  // Watched ports.
  input wire logic        ref_clk,
  input wire logic        reset_n,
  input wire logic [7:0]  sfr_addr,
  input wire logic        sfr_wr,
  input wire logic        sfr_rd,
  input wire logic [7:0]  sfr_wdata,
  input wire logic [7:0]  sfr_rdata,
  input wire logic        core_compare,
  input wire analog_cfg_t analog_cfg,
  input wire logic        latched_compare_out,
  input wire logic        raw_compare_out,
  input wire logic        reset_source,
  input wire logic        counter_array_kill,
  input wire logic        irq_request
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);
  AST_RAW_GATE: assert property (raw_compare_out == (core_compare && analog_cfg.power_on))
    else $error("raw output not gated by enable");
  AST_LATCH_RISE: assert property ($rose(latched_compare_out) |-> $past(raw_compare_out, 4))
    else $error("latched output rose without input");
  AST_LATCH_FALL: assert property ($fell(latched_compare_out) && analog_cfg.power_on |->
    !$past(raw_compare_out, 4)) else $error("latched output fell without input");
  AST_SOURCES: assert property ({reset_source, counter_array_kill} == {2{latched_compare_out}})
    else $error("reset or kill output differs");
  AST_CTRL_WR: assert property (sfr_wr && sfr_addr == ctrl_addr |=>
    analog_cfg[6:2] == {$past(sfr_wdata[7]), $past(sfr_wdata[3:0])}) else $error("control write lost");
  AST_MODE_WR: assert property (sfr_wr && sfr_addr == mode_addr |=>
    analog_cfg.response_speed_sel == $past(sfr_wdata[1:0])) else $error("mode write lost");
  AST_RD_ZERO: assert property (!(sfr_rd && (sfr_addr == ctrl_addr || sfr_addr == mode_addr)) |=>
    sfr_rdata == 8'h00) else $error("read data not zero");
  AST_RD_RESULT: assert property (sfr_rd && sfr_addr == ctrl_addr && analog_cfg.power_on |=>
    sfr_rdata[6] == $past(latched_compare_out)) else $error("result bit wrong");
  AST_IRQ_FALL: assert property ($fell(irq_request) |-> $past(sfr_wr))
    else $error("request dropped without write");
  // A result change lands four edges after the input changes; the request follows one edge later.
  AST_IRQ_RISE: assert property ($rose(irq_request) |-> $past(sfr_wr) ||
    $past(raw_compare_out, 5) != $past(raw_compare_out, 6)) else $error("request without cause");
  AST_OFF_LOW: assert property (!analog_cfg.power_on |-> !raw_compare_out && !latched_compare_out)
    else $error("output high while disabled");
endmodule // comparator_digital_control_sva
bind comparator_digital_control comparator_digital_control_sva sva_chk (.*);

/* test/comparator_digital_control_tb.sv */
`timescale 1ns/1ns
// ==========================================================
// Self-checking bench for the comparator control block.
module comparator_digital_control_tb
  import cmp_ctrl_pkg::*;
;
  logic        ref_clk;
  logic        reset_n;
  logic        clk_run;
  logic [7:0]  sfr_addr;
  logic        sfr_wr;
  logic        sfr_rd;
  logic [7:0]  sfr_wdata;
  logic [7:0]  sfr_rdata;
  logic        core_compare;
  analog_cfg_t analog_cfg;
  logic        latched_compare_out;
  logic        raw_compare_out;
  logic        irq_request;
  logic        target;
  logic        slow;
  logic        rd_seen;
  logic [15:0] seed;
  logic [7:0]  exp_q[$];
  int          failures;
  int          checks_done;
  comparator_digital_control uut (
    .ref_clk             (ref_clk),
    .reset_n             (reset_n),
    .sfr_addr            (sfr_addr),
    .sfr_wr              (sfr_wr),
    .sfr_rd              (sfr_rd),
    .sfr_wdata           (sfr_wdata),
    .sfr_rdata           (sfr_rdata),
    .core_compare        (core_compare),
    .analog_cfg          (analog_cfg),
    .latched_compare_out (latched_compare_out),
    .raw_compare_out     (raw_compare_out),
    .reset_source        (),
    .counter_array_kill  (),
    .irq_request         (irq_request)
  );
  analog_core_model core (.target(target), .slow(slow), .core_out(core_compare));
  // Clock that can be held still to mimic stop mode.
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = clk_run ? ~ref_clk : ref_clk;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic complete_run();
    // A read whose data never came back counts as a mismatch.
    if (exp_q.size() != 0)
      failures++;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    sfr_wr <= w;
    sfr_rd <= r;
    sfr_addr <= a;
    sfr_wdata <= d;
    @(posedge ref_clk);
  endtask
  task automatic idle(input int n);
    repeat (n) begin
      seed = lfsr(seed);
      bus(1'b0, 1'b0, seed[7:0], seed[15:8]);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus(1'b0, 1'b1, a, 8'h00);
  endtask
  task automatic settle(input logic v);
    int n;
    n = 0;
    while (latched_compare_out !== v && n < 20) begin
      idle(1);
      n++;
    end
    if (n == 20) begin
      failures++;
      complete_run();
    end
  endtask
  // Read data stands one cycle after the read edge; compare it with the oldest note.
  always @(posedge ref_clk) begin
    rd_seen <= sfr_rd;
    if (rd_seen === 1'b1 && exp_q.size() > 0)
      chk(exp_q.pop_front(), sfr_rdata);
  end
  // Main sequence.
  initial begin
    clk_run = 1'b1;
    reset_n = 1'b0;
    {sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = '0;
    {target, slow} = 2'h0;
    seed = 16'hb18d;
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    idle(2);
    chk(8'h02, {1'b0, analog_cfg});
    rd(ctrl_addr, ctrl_reset);
    rd(mode_addr, mode_reset);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 1'b0, ctrl_addr, {4'h8, i[1:0], ~i[1:0]});
      bus(1'b1, 1'b0, mode_addr, {6'h0c, i[1:0]});
      rd(mode_addr, {6'h0c, i[1:0]});
      chk({2'h1, i[1:0], ~i[1:0], i[1:0]}, {1'b0, analog_cfg});
    end
    $display("test config done");
    target <= 1'b1;
    settle(1'b1);
    idle(1);
    chk(8'h01, {7'h0, irq_request});
    rd(ctrl_addr, 8'hec);
    bus(1'b1, 1'b0, ctrl_addr, 8'h8c);
    slow <= 1'b1;
    target <= 1'b0;
    settle(1'b0);
    idle(1);
    chk(8'h01, {7'h0, irq_request});
    rd(ctrl_addr, 8'h9c);
    bus(1'b1, 1'b0, mode_addr, 8'h02);
    target <= 1'b1;
    settle(1'b1);
    idle(1);
    chk(8'h00, {7'h0, irq_request});
    bus(1'b1, 1'b0, mode_addr, 8'h20);
    idle(1);
    chk(8'h01, {7'h0, irq_request});
    $display("test edges done");
    clk_run = 1'b0;
    target <= 1'b0;
    #310;
    chk(8'h00, {7'h0, raw_compare_out});
    target <= 1'b1;
    #310;
    chk(8'h01, {7'h0, raw_compare_out});
    clk_run = 1'b1;
    idle(2);
    $display("test stop done");
    bus(1'b1, 1'b0, ctrl_addr, 8'h0c);
    idle(1);
    chk(8'h00, {7'h0, raw_compare_out});
    settle(1'b0);
    // The gated input needs four edges to reach the result bit and five to reach the falling flag.
    idle(4);
    rd(ctrl_addr, 8'h1c);
    bus(1'b1, 1'b0, 8'h9c, 8'hff);
    bus(1'b1, 1'b0, ctrl_addr, 8'h40);
    bus(1'b1, 1'b0, mode_addr, 8'hff);
    rd(ctrl_addr, 8'h00);
    rd(mode_addr, 8'h33);
    rd(8'h9c, 8'h00);
    idle(2);
    $display("test refuse done");
    complete_run();
  end
endmodule // comparator_digital_control_tb
